// file: rtl/gpiop_port.sv
`timescale 1ns/100ps
`default_nettype none
module gpiop_port
#(
	parameter logic [7:0]  DEBUG_PINS = 8'h00,
	parameter logic [7:0]  PIN_MASK   = 8'hFF,
	// Arbitrary values
	parameter logic [31:0] LOCK_KEY   = 32'h0000_5A5A,
	parameter logic [95:0] IDENT      = 96'h0102_0304_0506_0708_090A_0B0C
)
(
	// Clock, reset, enable
	input  wire logic                   I_SYS_CLK,
	input  wire logic                   I_ARST_N,
	input  wire logic                   I_CE,
	// Register access
	input  wire gpiop_pkg::gpiop_acc_t  I_ACC,
	output logic [31:0]                 O_RDATA,
	output logic                        O_RVALID,
	// Pins
	input  wire logic [7:0]             I_PIN_IN,
	output logic [7:0]                  O_PIN_OUT,
	output logic [7:0]                  O_PIN_OE_N,
	output gpiop_pkg::gpiop_pad_t       O_PAD,
	// Peripherals
	input  wire logic [7:0]             I_ALT_OUT,
	input  wire logic [7:0]             I_ALT_OE,
	output logic [7:0]                  O_ALT_IN,
	output logic [7:0]                  O_ALT_SEL,
	// Interrupt and converter trigger
	output logic [7:0]                  O_RIS,
	output logic [7:0]                  O_MIS,
	output logic                        O_INTR,
	output logic                        O_ADC_TRIG
);
	localparam gpiop_pkg::gpiop_pad_t PAD_RST = '{
		drive_two_ma_select:  gpiop_pkg::DR2R_RST,
		pull_up_enable:       DEBUG_PINS,
		digital_input_enable: DEBUG_PINS,
		default:              gpiop_pkg::ZERO_RST
	};
	localparam gpiop_pkg::gpiop_st_t RST_ST = '{
		alt_function_select: DEBUG_PINS,
		commit_permit_mask:  ~DEBUG_PINS,
		pad:                 PAD_RST,
		rdata:               gpiop_pkg::RDATA_RST,
		unlocked:            1'b0,
		rvalid:              1'b0,
		intr:                1'b0,
		trig:                1'b0,
		pin_oe_n:            gpiop_pkg::OE_N_RST,
		default:             gpiop_pkg::ZERO_RST
	};

	gpiop_pkg::gpiop_st_t st;
	gpiop_pkg::gpiop_st_t next_st;
	logic [7:0]           pin_in;
	logic [7:0]           cond;
	logic [7:0]           cond_raw;
	logic [7:0]           dmask;
	logic [7:0]           wd;
	logic [7:0]           clr;
	logic [7:0]           wdat;
	logic [7:0]           af_we;
	logic [7:0]           val;
	logic [7:0]           drv;
	logic [3:0]           idx;

	function automatic logic wr_hit(input gpiop_pkg::gpiop_acc_t a, input gpiop_pkg::gpiop_sel_t s);
		wr_hit = a.wr && (a.sel == s);
	endfunction : wr_hit

	function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] nw);
		wmerge = gpiop_pkg::gpiop_merge(old, nw, PIN_MASK);
	endfunction : wmerge

	assign pin_in = st.sync2 & st.pad.digital_input_enable & PIN_MASK;
	assign dmask  = I_ACC.addr[9:gpiop_pkg::MASK_LSB];
	assign wd     = I_ACC.wdata[7:0];
	assign idx    = I_ACC.addr[5:2];
	// Disabled or unconnected pins raise no condition, a low level included
	assign cond   = cond_raw & st.pad.digital_input_enable & PIN_MASK;

	gpiop_trig u_trig
	(
		.i_cur   (pin_in),
		.i_prev  (st.prev & st.pad.digital_input_enable & PIN_MASK),
		.i_sense (st.interrupt_sense_select),
		.i_both  (st.interrupt_both_edges),
		.i_event (st.interrupt_event_polarity),
		.o_cond  (cond_raw)
	);

	always_comb
	begin
		next_st       = st;
		next_st.sync1 = I_PIN_IN;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;
		clr   = wr_hit(I_ACC, gpiop_pkg::SEL_ICR) ? (wd & PIN_MASK) : 8'h00;
		af_we = PIN_MASK & (~DEBUG_PINS | (st.commit_permit_mask & {8{st.unlocked}}));
		// Masked data write; bits address as one of 256 words
		wdat = wr_hit(I_ACC, gpiop_pkg::SEL_DATA)
			? gpiop_pkg::gpiop_merge(st.pin_data_value, wd, dmask & PIN_MASK)
			: st.pin_data_value;
		next_st.pin_data_value = (wdat & st.direction_select)
			| (pin_in & ~st.direction_select);
		if (I_ACC.wr)
		begin
			unique case (I_ACC.sel)
				gpiop_pkg::SEL_DIR:
					next_st.direction_select = wmerge(st.direction_select, wd);
				gpiop_pkg::SEL_IS:
					next_st.interrupt_sense_select = wmerge(st.interrupt_sense_select, wd);
				gpiop_pkg::SEL_IBE:
					next_st.interrupt_both_edges = wmerge(st.interrupt_both_edges, wd);
				gpiop_pkg::SEL_IEV:
					next_st.interrupt_event_polarity = wmerge(st.interrupt_event_polarity, wd);
				gpiop_pkg::SEL_IM:
					next_st.interrupt_mask_enable = wmerge(st.interrupt_mask_enable, wd);
				gpiop_pkg::SEL_AFSEL:
					next_st.alt_function_select = gpiop_pkg::gpiop_merge(st.alt_function_select,
						wd, af_we);
				gpiop_pkg::SEL_DR2R:
				begin
					next_st.pad.drive_two_ma_select   = wmerge(st.pad.drive_two_ma_select, wd);
					next_st.pad.drive_four_ma_select  = st.pad.drive_four_ma_select & ~wd;
					next_st.pad.drive_eight_ma_select = st.pad.drive_eight_ma_select & ~wd;
				end
				gpiop_pkg::SEL_DR4R:
				begin
					next_st.pad.drive_four_ma_select  = wmerge(st.pad.drive_four_ma_select, wd);
					next_st.pad.drive_two_ma_select   = st.pad.drive_two_ma_select & ~wd;
					next_st.pad.drive_eight_ma_select = st.pad.drive_eight_ma_select & ~wd;
				end
				gpiop_pkg::SEL_DR8R:
				begin
					next_st.pad.drive_eight_ma_select = wmerge(st.pad.drive_eight_ma_select, wd);
					next_st.pad.drive_two_ma_select   = st.pad.drive_two_ma_select & ~wd;
					next_st.pad.drive_four_ma_select  = st.pad.drive_four_ma_select & ~wd;
				end
				gpiop_pkg::SEL_ODR:
					next_st.pad.open_drain_select = wmerge(st.pad.open_drain_select, wd);
				gpiop_pkg::SEL_PUR:
					next_st.pad.pull_up_enable = wmerge(st.pad.pull_up_enable, wd);
				gpiop_pkg::SEL_PDR:
					next_st.pad.pull_down_enable = wmerge(st.pad.pull_down_enable, wd);
				gpiop_pkg::SEL_DEN:
					next_st.pad.digital_input_enable = wmerge(st.pad.digital_input_enable, wd);
				gpiop_pkg::SEL_SLR:
					next_st.pad.slew_control = wmerge(st.pad.slew_control, wd);
				gpiop_pkg::SEL_LOCK:
					next_st.unlocked = (I_ACC.wdata == LOCK_KEY);
				gpiop_pkg::SEL_CR:
					if (st.unlocked)
					begin
						next_st.commit_permit_mask = gpiop_pkg::gpiop_merge(st.commit_permit_mask,
							wd, DEBUG_PINS);
					end
				default: ;
			endcase
		end
		// Sticky status, a new event wins over its clear
		next_st.raw_interrupt_status = ((st.raw_interrupt_status & ~clr) | cond) & PIN_MASK;
		next_st.masked_interrupt_status = next_st.raw_interrupt_status
			& next_st.interrupt_mask_enable;
		next_st.intr = |next_st.masked_interrupt_status;
		next_st.trig = cond[gpiop_pkg::TRIG_BIT]
			& st.interrupt_mask_enable[gpiop_pkg::TRIG_BIT];
		// Pin drive
		val = (next_st.alt_function_select & I_ALT_OUT)
			| (~next_st.alt_function_select & next_st.pin_data_value);
		drv = (next_st.alt_function_select & I_ALT_OE)
			| (~next_st.alt_function_select & next_st.direction_select);
		drv = drv & ~(next_st.pad.open_drain_select & val)
			& next_st.pad.digital_input_enable & PIN_MASK;
		next_st.pin_out  = val;
		next_st.pin_oe_n = ~drv;
		next_st.alt_in   = pin_in;
		// Read answer
		next_st.rvalid = I_ACC.rd;
		if (I_ACC.rd)
		begin
			next_st.rdata = gpiop_pkg::RDATA_RST;
			unique case (I_ACC.sel)
				gpiop_pkg::SEL_DATA:  next_st.rdata[7:0] = st.pin_data_value & dmask;
				gpiop_pkg::SEL_DIR:   next_st.rdata[7:0] = st.direction_select;
				gpiop_pkg::SEL_IS:    next_st.rdata[7:0] = st.interrupt_sense_select;
				gpiop_pkg::SEL_IBE:   next_st.rdata[7:0] = st.interrupt_both_edges;
				gpiop_pkg::SEL_IEV:   next_st.rdata[7:0] = st.interrupt_event_polarity;
				gpiop_pkg::SEL_IM:    next_st.rdata[7:0] = st.interrupt_mask_enable;
				gpiop_pkg::SEL_RIS:   next_st.rdata[7:0] = st.raw_interrupt_status;
				gpiop_pkg::SEL_MIS:   next_st.rdata[7:0] = st.masked_interrupt_status;
				gpiop_pkg::SEL_AFSEL: next_st.rdata[7:0] = st.alt_function_select;
				gpiop_pkg::SEL_DR2R:  next_st.rdata[7:0] = st.pad.drive_two_ma_select;
				gpiop_pkg::SEL_DR4R:  next_st.rdata[7:0] = st.pad.drive_four_ma_select;
				gpiop_pkg::SEL_DR8R:  next_st.rdata[7:0] = st.pad.drive_eight_ma_select;
				gpiop_pkg::SEL_ODR:   next_st.rdata[7:0] = st.pad.open_drain_select;
				gpiop_pkg::SEL_PUR:   next_st.rdata[7:0] = st.pad.pull_up_enable;
				gpiop_pkg::SEL_PDR:   next_st.rdata[7:0] = st.pad.pull_down_enable;
				gpiop_pkg::SEL_DEN:   next_st.rdata[7:0] = st.pad.digital_input_enable;
				gpiop_pkg::SEL_SLR:   next_st.rdata[7:0] = st.pad.slew_control;
				gpiop_pkg::SEL_LOCK:  next_st.rdata[0] = ~st.unlocked;
				gpiop_pkg::SEL_CR:    next_st.rdata[7:0] = st.commit_permit_mask;
				gpiop_pkg::SEL_IDENT:
					if (idx < 4'(gpiop_pkg::IDENT_NUM))
					begin
						next_st.rdata[7:0] = IDENT[idx * 8 +: 8];
					end
				default: ;
			endcase
		end
	end

	// Any reset restores the defaults
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			st <= RST_ST;
		end
		else if (I_CE)
		begin
			st <= next_st;
		end
	end

	assign O_RDATA    = st.rdata;
	assign O_RVALID   = st.rvalid;
	assign O_PIN_OUT  = st.pin_out;
	assign O_PIN_OE_N = st.pin_oe_n;
	assign O_PAD      = st.pad;
	assign O_ALT_IN   = st.alt_in;
	assign O_ALT_SEL  = st.alt_function_select;
	assign O_RIS      = st.raw_interrupt_status;
	assign O_MIS      = st.masked_interrupt_status;
	assign O_INTR     = st.intr;
	assign O_ADC_TRIG = st.trig;

	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	sequence s_clear_req;
		I_CE && (clr != 8'h00);
	endsequence

	sequence s_data_write;
		I_CE && wr_hit(I_ACC, gpiop_pkg::SEL_DATA);
	endsequence

	sequence s_icr_read;
		I_CE && I_ACC.rd && (I_ACC.sel == gpiop_pkg::SEL_ICR);
	endsequence

	sequence s_locked;
		I_CE && !st.unlocked;
	endsequence

	sequence s_trig_event;
		I_CE && cond[gpiop_pkg::TRIG_BIT] && st.interrupt_mask_enable[gpiop_pkg::TRIG_BIT];
	endsequence

	a_data_masked_write: assert property (s_data_write |=> (((st.pin_data_value ^ $past(wd))
		& $past(dmask) & $past(st.direction_select) & PIN_MASK) == 8'h00)
		&& (((st.pin_data_value ^ $past(st.pin_data_value))
		& ~$past(dmask) & $past(st.direction_select)) == 8'h00))
		else $error("masked data write wrong");

	a_data_read_mask: assert property (I_CE && I_ACC.rd && I_ACC.sel == gpiop_pkg::SEL_DATA
		|=> O_RVALID && O_RDATA == {24'h000000, $past(st.pin_data_value) & $past(dmask)})
		else $error("masked data read wrong");

	a_rvalid_pulse: assert property (I_CE |=> O_RVALID == $past(I_ACC.rd))
		else $error("read answer not one cycle later");

	a_icr_reads_zero: assert property (s_icr_read |=> O_RDATA == 32'h0000_0000)
		else $error("clear register read not zero");

	a_input_capture: assert property (I_CE |=> ((st.pin_data_value ^ $past(pin_in))
		& ~$past(st.direction_select)) == 8'h00)
		else $error("input bit did not capture pin");

	a_output_drive: assert property (((O_PIN_OUT ^ st.pin_data_value)
		& ~st.alt_function_select) == 8'h00)
		else $error("output bit not driven from data");

	a_alt_drive: assert property (I_CE |=> ((O_PIN_OUT ^ $past(I_ALT_OUT))
		& st.alt_function_select) == 8'h00)
		else $error("peripheral value not on pin");

	a_pin_undriven: assert property ((O_PIN_OE_N | O_PAD.digital_input_enable) == 8'hFF)
		else $error("pin driven without digital enable");

	a_ris_sticky: assert property (I_CE && clr == 8'h00
		|=> (st.raw_interrupt_status & $past(st.raw_interrupt_status)) == $past(st.raw_interrupt_status))
		else $error("latched condition lost");

	a_clear_one: assert property (s_clear_req |=> (st.raw_interrupt_status
		& $past(clr) & ~$past(cond)) == 8'h00)
		else $error("clear did not clear");

	a_mis_and_raw: assert property (O_MIS == (O_RIS & st.interrupt_mask_enable)
		&& O_INTR == (O_MIS != 8'h00))
		else $error("masked status or interrupt wrong");

	a_adc_trig_pulse: assert property (s_trig_event
		|=> O_ADC_TRIG && (O_INTR || !st.interrupt_mask_enable[gpiop_pkg::TRIG_BIT]))
		else $error("converter trigger missing");

	a_lock_guard: assert property (s_locked
		|=> ((st.alt_function_select ^ $past(st.alt_function_select)) & DEBUG_PINS) == 8'h00)
		else $error("protected bit changed while locked");

	a_commit_locked: assert property (s_locked
		|=> st.commit_permit_mask == $past(st.commit_permit_mask))
		else $error("commit permits changed while locked");

	a_unused_bits: assert property (((st.direction_select | st.interrupt_mask_enable) & ~PIN_MASK) == 8'h00)
		else $error("unconnected bit was written");

	a_drive_exclusive: assert property (((O_PAD.drive_two_ma_select & O_PAD.drive_four_ma_select)
		| (O_PAD.drive_two_ma_select & O_PAD.drive_eight_ma_select)
		| (O_PAD.drive_four_ma_select & O_PAD.drive_eight_ma_select)) == 8'h00)
		else $error("two drive strengths selected");
endmodule : gpiop_port
`default_nettype wire

// file: rtl/gpiop_pkg.sv
package gpiop_pkg;
	// Port shape
	localparam int unsigned NPIN      = 8;
	localparam int unsigned TRIG_BIT  = 4;
	localparam int unsigned MASK_LSB  = 2;
	localparam int unsigned IDENT_NUM = 12;

	// Debug pin groups of the two ports that carry them
	localparam logic [7:0] PORTB_DEBUG = 8'h80;
	localparam logic [7:0] PORTC_DEBUG = 8'h0F;

	// Reset values
	localparam logic [7:0]  ZERO_RST  = 8'h00;
	localparam logic [7:0]  DR2R_RST  = 8'hFF;
	localparam logic [7:0]  OE_N_RST  = 8'hFF;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// Register selects of the access port
	typedef enum logic [4:0] {
		SEL_DATA  = 5'h00,
		SEL_DIR   = 5'h01,
		SEL_IS    = 5'h02,
		SEL_IBE   = 5'h03,
		SEL_IEV   = 5'h04,
		SEL_IM    = 5'h05,
		SEL_RIS   = 5'h06,
		SEL_MIS   = 5'h07,
		SEL_ICR   = 5'h08,
		SEL_AFSEL = 5'h09,
		SEL_DR2R  = 5'h0A,
		SEL_DR4R  = 5'h0B,
		SEL_DR8R  = 5'h0C,
		SEL_ODR   = 5'h0D,
		SEL_PUR   = 5'h0E,
		SEL_PDR   = 5'h0F,
		SEL_DEN   = 5'h10,
		SEL_SLR   = 5'h11,
		SEL_LOCK  = 5'h12,
		SEL_CR    = 5'h13,
		SEL_IDENT = 5'h14
	} gpiop_sel_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		gpiop_sel_t sel;
		logic [9:0] addr;
		logic [31:0] wdata;
	} gpiop_acc_t;

	typedef struct packed {
		logic [7:0] drive_two_ma_select;
		logic [7:0] drive_four_ma_select;
		logic [7:0] drive_eight_ma_select;
		logic [7:0] open_drain_select;
		logic [7:0] pull_up_enable;
		logic [7:0] pull_down_enable;
		logic [7:0] slew_control;
		logic [7:0] digital_input_enable;
	} gpiop_pad_t;

	typedef struct packed {
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic [7:0]  prev;
		logic [7:0]  pin_data_value;
		logic [7:0]  direction_select;
		logic [7:0]  interrupt_sense_select;
		logic [7:0]  interrupt_both_edges;
		logic [7:0]  interrupt_event_polarity;
		logic [7:0]  interrupt_mask_enable;
		logic [7:0]  raw_interrupt_status;
		logic [7:0]  masked_interrupt_status;
		logic [7:0]  alt_function_select;
		logic [7:0]  commit_permit_mask;
		logic        unlocked;
		gpiop_pad_t  pad;
		logic [31:0] rdata;
		logic        rvalid;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe_n;
		logic [7:0]  alt_in;
		logic        intr;
		logic        trig;
	} gpiop_st_t;

	// Replace the bits of old selected by m with those of nw
	function automatic logic [7:0] gpiop_merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		gpiop_merge = (old & ~m) | (nw & m);
	endfunction : gpiop_merge
endpackage : gpiop_pkg

// file: rtl/gpiop_trig.sv
`timescale 1ns/100ps
`default_nettype none
module gpiop_trig
(
	// Pin levels now and one sample before
	input  wire logic [7:0] i_cur,
	input  wire logic [7:0] i_prev,
	// Trigger settings
	input  wire logic [7:0] i_sense,
	input  wire logic [7:0] i_both,
	input  wire logic [7:0] i_event,
	// Per-pin trigger condition
	output logic      [7:0] o_cond
);
	logic [7:0] lvl;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] edg;

	always_comb
	begin
		lvl    = ~(i_cur ^ i_event);
		rise   = i_cur & ~i_prev;
		fall   = ~i_cur & i_prev;
		edg    = (i_both & (rise | fall)) | (~i_both & i_event & rise)
			| (~i_both & ~i_event & fall);
		o_cond = (i_sense & lvl) | (~i_sense & edg);
	end
endmodule : gpiop_trig
`default_nettype wire

// file: tb/gpiop_board.sv
`timescale 1ns/100ps
`default_nettype none
module gpiop_board
(
	// Clock
	input  wire logic                  i_clk,
	// Device side of the pads
	input  wire logic [7:0]            i_pin_out,
	input  wire logic [7:0]            i_pin_oe_n,
	input  wire gpiop_pkg::gpiop_pad_t i_pad,
	// Board drivers
	input  wire logic [7:0]            i_drv_val,
	input  wire logic [7:0]            i_drv_en,
	// Resolved pad level
	output logic [7:0]                 o_lvl
);
	logic [7:0] last;

	// Device drive wins; a floating pad with no pull keeps flipping
	always_comb
	begin
		for (int b = 0; b < 8; b++)
		begin
			if (!i_pin_oe_n[b])
				o_lvl[b] = i_pin_out[b];
			else if (i_drv_en[b])
				o_lvl[b] = i_drv_val[b];
			else if (i_pad.pull_up_enable[b])
				o_lvl[b] = 1'b1;
			else if (i_pad.pull_down_enable[b])
				o_lvl[b] = 1'b0;
			else
				o_lvl[b] = ~last[b];
		end
	end

	always_ff @(posedge i_clk)
		last <= o_lvl;
endmodule : gpiop_board
`default_nettype wire

// file: tb/gpiop_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module gpiop_port_tb_top;
	localparam logic [31:0] KEY = 32'h0000_C3A5; // Arbitrary unlock value
	localparam logic [95:0] ID_WORDS = 96'h1E2D_3C4B_5A69_7887_96A5_B4C3; // Arbitrary identification bytes
	logic                  clk;
	logic                  rst_n;
	gpiop_pkg::gpiop_acc_t acc;
	gpiop_pkg::gpiop_pad_t pad;
	logic [31:0]           rdata;
	logic [31:0]           got;
	logic [31:0]           id0;
	logic                  rvalid;
	logic                  intr;
	logic                  trig;
	logic [7:0]            pin_lvl, pin_out, pin_oe_n, alt_out, alt_oe, alt_in, alt_sel, ris, mis;
	logic [7:0]            drv_val, drv_en, shadow;
	logic [7:0]            masks [6] = '{8'h26, 8'h31, 8'hFF, 8'h00, 8'h81, 8'h5A};
	logic [7:0]            vals [6] = '{8'hEB, 8'h7C, 8'h3C, 8'hFF, 8'h99, 8'hA5};
	logic [3:0]            cfg [5] = '{4'b0001, 4'b1000, 4'b0010, 4'b0101, 4'b1100};
	int                    num_errors = 0;
	int                    tests_run = 0;
	int                    cycles = 0;
	int                    trig_cnt = 0;
	int                    n;

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	gpiop_port #(.DEBUG_PINS(gpiop_pkg::PORTB_DEBUG), .LOCK_KEY(KEY), .IDENT(ID_WORDS)) i_gpiop_port
	(
		.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_CE(1'b1), .I_ACC(acc), .O_RDATA(rdata), .O_RVALID(rvalid),
		.I_PIN_IN(pin_lvl), .O_PIN_OUT(pin_out), .O_PIN_OE_N(pin_oe_n), .O_PAD(pad), .I_ALT_OUT(alt_out),
		.I_ALT_OE(alt_oe), .O_ALT_IN(alt_in), .O_ALT_SEL(alt_sel), .O_RIS(ris), .O_MIS(mis),
		.O_INTR(intr), .O_ADC_TRIG(trig)
	);

	gpiop_board i_gpiop_board
	(
		.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .i_pad(pad), .i_drv_val(drv_val),
		.i_drv_en(drv_en), .o_lvl(pin_lvl)
	);

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	// Converter pulses and hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (trig === 1'b1)
			trig_cnt++;
		if (cycles == 20000)
		begin
			num_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic wr(input gpiop_pkg::gpiop_sel_t s, input logic [31:0] d, input logic [9:0] a = 10'h000);
		@(posedge clk);
		#1;
		acc = '{rd: 1'b0, wr: 1'b1, sel: s, addr: a, wdata: d};
		@(posedge clk);
		#1;
		acc.wr = 1'b0;
	endtask : wr

	task automatic rd(input gpiop_pkg::gpiop_sel_t s, input logic [9:0] a = 10'h000);
		@(posedge clk);
		#1;
		acc = '{rd: 1'b1, wr: 1'b0, sel: s, addr: a, wdata: 32'h0000_0000};
		@(posedge clk);
		#1;
		acc.rd = 1'b0;
		chk(rvalid, 1'h1);
		got = rdata;
	endtask : rd

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask : do_reset

	task automatic chk_defaults();
		chk(alt_sel, gpiop_pkg::PORTB_DEBUG);
		chk(pad.pull_up_enable, gpiop_pkg::PORTB_DEBUG);
		chk(pad.digital_input_enable, gpiop_pkg::PORTB_DEBUG);
		chk(pad.pull_down_enable, 8'h00);
		chk(pad.drive_two_ma_select, 8'hFF);
		chk(pin_oe_n, 8'hFF);
		rd(gpiop_pkg::SEL_CR);
		chk(got, 32'h0000_007F);
		rd(gpiop_pkg::SEL_AFSEL);
		chk(got, 32'h0000_0080);
	endtask : chk_defaults

	initial
	begin
		acc = '0;
		rst_n = 1'b0;
		drv_val = 8'h00;
		drv_en = 8'hFF;
		alt_out = 8'h00;
		alt_oe = 8'h00;
		do_reset();
		chk_defaults();
		// Commit protection of the debug pin
		wr(gpiop_pkg::SEL_AFSEL, 8'h01);
		chk(alt_sel, 8'h81);
		wr(gpiop_pkg::SEL_CR, 8'h00);
		rd(gpiop_pkg::SEL_CR);
		chk(got, 32'h0000_007F);
		wr(gpiop_pkg::SEL_LOCK, KEY);
		wr(gpiop_pkg::SEL_AFSEL, 8'h00);
		chk(alt_sel, 8'h80);
		wr(gpiop_pkg::SEL_CR, 8'hFF);
		wr(gpiop_pkg::SEL_AFSEL, 8'h00);
		chk(alt_sel, 8'h00);
		// Masked data access on output pins
		wr(gpiop_pkg::SEL_DEN, 8'hFF);
		wr(gpiop_pkg::SEL_DIR, 8'hFF);
		shadow = 8'h00;
		for (int i = 0; i < 6; i++)
		begin
			wr(gpiop_pkg::SEL_DATA, vals[i], {masks[i], 2'b00});
			shadow = (shadow & ~masks[i]) | (vals[i] & masks[i]);
			settle();
			chk(pin_out, shadow);
			chk(pin_oe_n, 8'h00);
			rd(gpiop_pkg::SEL_DATA, {masks[5 - i], 2'b00});
			chk(got, shadow & masks[5 - i]);
		end
		// Inputs
		wr(gpiop_pkg::SEL_DIR, 8'h00);
		drv_val = 8'h5A;
		settle();
		settle();
		rd(gpiop_pkg::SEL_DATA, 10'h3FC);
		chk(got, 32'h0000_005A);
		chk(pin_oe_n, 8'hFF);
		// Peripheral takes pin 0
		wr(gpiop_pkg::SEL_AFSEL, 8'h01);
		alt_out = 8'h01;
		alt_oe = 8'h01;
		settle();
		settle();
		chk(pin_out[0], 1'h1);
		chk(pin_oe_n, 8'hFE);
		chk(alt_in, 8'h5B);
		alt_oe = 8'h00;
		wr(gpiop_pkg::SEL_AFSEL, 8'h00);
		// Trigger modes on the converter pin, one table row each
		for (int k = 0; k < 5; k++)
		begin
			wr(gpiop_pkg::SEL_IM, 8'h00);
			drv_val = {3'b000, cfg[k][3], 4'h0};
			wr(gpiop_pkg::SEL_IS, {27'h0, cfg[k][2], 4'h0});
			wr(gpiop_pkg::SEL_IBE, {27'h0, cfg[k][1], 4'h0});
			wr(gpiop_pkg::SEL_IEV, {27'h0, cfg[k][0], 4'h0});
			settle();
			settle();
			wr(gpiop_pkg::SEL_ICR, 8'hFF);
			wr(gpiop_pkg::SEL_IM, 8'h10);
			chk(ris, 8'h00);
			n = trig_cnt;
			drv_val[4] = ~cfg[k][3];
			repeat (5) @(posedge clk);
			#1;
			chk(ris, 8'h10);
			chk(mis, 8'h10);
			chk(intr, 1'h1);
			if (k < 3)
				chk(trig_cnt - n, 32'h1);
			wr(gpiop_pkg::SEL_IM, 8'h00);
			chk(mis, 8'h00);
			chk(intr, 1'h0);
			chk(ris, 8'h10);
			wr(gpiop_pkg::SEL_ICR, 8'h00);
			chk(ris, 8'h10);
			rd(gpiop_pkg::SEL_ICR);
			chk(got, 32'h0000_0000);
			drv_val[4] = cfg[k][3];
			settle();
			settle();
			wr(gpiop_pkg::SEL_ICR, 8'h10);
			settle();
			chk(ris, 8'h00);
		end
		// Identification words are fixed
		rd(gpiop_pkg::SEL_IDENT);
		id0 = got;
		chk(got, {24'h000000, ID_WORDS[7:0]});
		wr(gpiop_pkg::SEL_IDENT, 8'hFF);
		rd(gpiop_pkg::SEL_IDENT);
		chk(got, id0);
		rd(gpiop_pkg::SEL_IDENT, 10'h030);
		chk(got, 32'h0000_0000);
		rd(gpiop_pkg::SEL_IDENT, 10'h02C);
		chk(got, {24'h000000, ID_WORDS[95:88]});
		// Pad settings: one drive strength per pin, open drain drives only low
		wr(gpiop_pkg::SEL_DR8R, 8'h0F);
		chk(pad.drive_eight_ma_select, 8'h0F);
		chk(pad.drive_two_ma_select, 8'hF0);
		wr(gpiop_pkg::SEL_DR4R, 8'h03);
		chk(pad.drive_four_ma_select, 8'h03);
		chk(pad.drive_eight_ma_select, 8'h0C);
		wr(gpiop_pkg::SEL_SLR, 8'h3C);
		wr(gpiop_pkg::SEL_PDR, 8'h05);
		rd(gpiop_pkg::SEL_SLR);
		chk(got, 32'h0000_003C);
		chk(pad.pull_down_enable, 8'h05);
		wr(gpiop_pkg::SEL_ODR, 8'h01);
		wr(gpiop_pkg::SEL_DIR, 8'h01);
		wr(gpiop_pkg::SEL_DATA, 8'h00, 10'h004);
		chk(pin_oe_n, 8'hFE);
		wr(gpiop_pkg::SEL_DATA, 8'h01, 10'h004);
		chk(pin_oe_n, 8'hFF);
		// Second reset restores every default
		do_reset();
		chk_defaults();
		close_out();
	end
endmodule : gpiop_port_tb_top
`default_nettype wire
